// file: rtl/sercfg_pkg.sv
package sercfg_pkg;
    // ==========================================
    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    // ==========================================
    // Control register fields
    localparam int CTRL_SELF_TEST_BIT = 0;
    localparam int CTRL_MODE_LO_BIT = 1;
    localparam int CTRL_EDGE_BIT = 3;
    localparam int CTRL_SWING_BIT = 4;
    localparam int CTRL_PREEMPH_BIT = 5;
    localparam int CTRL_OVERRIDE_BIT = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [6:0] CTRL_MASK = 7'h7f;
    // ==========================================
    // Link modes
    typedef enum logic [1:0] {
        MODE_PLAIN = 2'b00,
        MODE_FILTERED = 2'b01,
        MODE_LEGACY_A = 2'b10,
        MODE_LEGACY_B = 2'b11
    } link_mode_t;
    // ==========================================
    // Glitch filter: control pulses shorter than this many clocks are dropped
    localparam logic [1:0] FILTER_CYCLES = 2'd3;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : sercfg_pkg

// file: rtl/sercfg_top.sv
`timescale 1ns/1ns
module sercfg_top (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    // Configuration pins
    input wire logic I_SELF_TEST_ENABLE,
    input wire logic [1:0] I_LINK_MODE,
    input wire logic I_POWER_DOWN_N,
    input wire logic I_LATCH_EDGE_SELECT,
    input wire logic I_OUTPUT_SWING_SELECT,
    input wire logic I_PREEMPHASIS_CONTROL,
    // Video control inputs
    input wire logic I_VIDEO_DATA_ENABLE,
    input wire logic I_HORIZONTAL_SYNC,
    input wire logic I_VERTICAL_SYNC,
    // AXI4-Lite write address
    input wire logic [7:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    // AXI4-Lite write response
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    // AXI4-Lite read address
    input wire logic [7:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // Effective configuration to the datapath
    output logic O_SELF_TEST_ON,
    output logic [1:0] O_LINK_MODE,
    output logic O_FILTER_ON,
    output logic O_LEGACY_A,
    output logic O_LEGACY_B,
    output logic O_LATCH_RISING,
    output logic O_SWING_LARGE,
    output logic O_PREEMPH_ON,
    output logic O_PLL_ENABLE,
    output logic O_SERIAL_FORCE_HIGH,
    // Video control to the datapath (data enable and hsync filtered, vsync passed through)
    output logic O_VIDEO_DATA_ENABLE,
    output logic O_HORIZONTAL_SYNC,
    output logic O_VERTICAL_SYNC
);
    // ==========================================
    // Control register and its pin/register selection
    logic [6:0] ctrl;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire override = ctrl[sercfg_pkg::CTRL_OVERRIDE_BIT];
    wire eff_self_test = override ? ctrl[sercfg_pkg::CTRL_SELF_TEST_BIT] : I_SELF_TEST_ENABLE;
    wire [1:0] eff_mode = override ? ctrl[sercfg_pkg::CTRL_MODE_LO_BIT +: 2] : I_LINK_MODE;
    wire eff_edge = override ? ctrl[sercfg_pkg::CTRL_EDGE_BIT] : I_LATCH_EDGE_SELECT;
    wire eff_swing = override ? ctrl[sercfg_pkg::CTRL_SWING_BIT] : I_OUTPUT_SWING_SELECT;
    // Pin is active when its external resistor pulls it low; floating reads high
    wire eff_preemph = ~I_PREEMPHASIS_CONTROL | ctrl[sercfg_pkg::CTRL_PREEMPH_BIT];
    wire powered = I_POWER_DOWN_N;
    wire filter_sel = (eff_mode == sercfg_pkg::MODE_FILTERED);
    // ==========================================
    // Write channel: address and data taken in either order
    wire aw_fire = I_AWVALID & O_AWREADY;
    wire w_fire = I_WVALID & O_WREADY;
    wire have_aw = aw_held | aw_fire;
    wire have_w = w_held | w_fire;
    wire [7:0] wr_addr = aw_held ? aw_addr : I_AWADDR;
    wire [31:0] wr_data = w_held ? w_data : I_WDATA;
    wire [3:0] wr_strb = w_held ? w_strb : I_WSTRB;
    wire wr_go = have_aw & have_w & ~O_BVALID;
    wire wr_hit = (wr_addr == sercfg_pkg::CTRL_OFFSET);
    wire wr_ok = wr_hit | (wr_addr == sercfg_pkg::STATUS_OFFSET);
    wire [6:0] wr_new = wr_strb[0] ? (wr_data[6:0] & sercfg_pkg::CTRL_MASK) : ctrl;
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N || !powered) begin
            ctrl <= sercfg_pkg::CTRL_RESET[6:0];
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
            O_BVALID <= 1'b0;
            O_BRESP <= sercfg_pkg::RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_addr <= I_AWADDR;
            end
            if (w_fire) begin
                w_data <= I_WDATA;
                w_strb <= I_WSTRB;
            end
            aw_held <= have_aw & ~wr_go;
            w_held <= have_w & ~wr_go;
            O_AWREADY <= ~have_aw & ~O_BVALID & ~wr_go;
            O_WREADY <= ~have_w & ~O_BVALID & ~wr_go;
            if (wr_go) begin
                O_BVALID <= 1'b1;
                O_BRESP <= wr_ok ? sercfg_pkg::RESP_OKAY : sercfg_pkg::RESP_SLVERR;
                if (wr_hit) begin
                    ctrl <= wr_new;
                end
            end else if (O_BVALID && I_BREADY) begin
                O_BVALID <= 1'b0;
            end
        end
    end
    // ==========================================
    // Read channel
    wire ar_fire = I_ARVALID & O_ARREADY;
    wire [31:0] status_word = {20'h00000, eff_preemph, eff_swing, eff_edge, eff_mode, eff_self_test,
        filter_sel, powered, O_PREEMPH_ON, O_SWING_LARGE, O_LATCH_RISING, O_PLL_ENABLE};
    wire [31:0] rd_word = (I_ARADDR == sercfg_pkg::CTRL_OFFSET) ? {25'h0000000, ctrl} : status_word;
    wire rd_ok = (I_ARADDR == sercfg_pkg::CTRL_OFFSET) | (I_ARADDR == sercfg_pkg::STATUS_OFFSET);
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h0000_0000;
            O_RRESP <= sercfg_pkg::RESP_OKAY;
        end else begin
            O_ARREADY <= ~O_RVALID & ~ar_fire;
            if (ar_fire) begin
                O_RVALID <= 1'b1;
                O_RDATA <= rd_ok ? rd_word : 32'h0000_0000;
                O_RRESP <= rd_ok ? sercfg_pkg::RESP_OKAY : sercfg_pkg::RESP_SLVERR;
            end else if (O_RVALID && I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end
    // ==========================================
    // Effective configuration outputs
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            O_SELF_TEST_ON <= 1'b0;
            O_LINK_MODE <= sercfg_pkg::MODE_PLAIN;
            O_FILTER_ON <= 1'b0;
            O_LEGACY_A <= 1'b0;
            O_LEGACY_B <= 1'b0;
            O_LATCH_RISING <= 1'b0;
            O_SWING_LARGE <= 1'b0;
            O_PREEMPH_ON <= 1'b0;
            O_PLL_ENABLE <= 1'b0;
            O_SERIAL_FORCE_HIGH <= 1'b1;
        end else begin
            O_SELF_TEST_ON <= powered & eff_self_test;
            O_LINK_MODE <= eff_mode;
            O_FILTER_ON <= filter_sel;
            O_LEGACY_A <= (eff_mode == sercfg_pkg::MODE_LEGACY_A);
            O_LEGACY_B <= (eff_mode == sercfg_pkg::MODE_LEGACY_B);
            O_LATCH_RISING <= eff_edge;
            O_SWING_LARGE <= eff_swing;
            O_PREEMPH_ON <= eff_preemph;
            O_PLL_ENABLE <= powered;
            O_SERIAL_FORCE_HIGH <= ~powered;
        end
    end
    // ==========================================
    // Control-signal glitch filter; assumes the source keeps the rate limits
    logic [1:0] de_cnt, hs_cnt;
    wire de_diff = I_VIDEO_DATA_ENABLE != O_VIDEO_DATA_ENABLE;
    wire hs_diff = I_HORIZONTAL_SYNC != O_HORIZONTAL_SYNC;
    wire de_take = ~filter_sel | (de_diff & de_cnt == sercfg_pkg::FILTER_CYCLES - 2'd1);
    wire hs_take = ~filter_sel | (hs_diff & hs_cnt == sercfg_pkg::FILTER_CYCLES - 2'd1);
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            de_cnt <= 2'd0;
            hs_cnt <= 2'd0;
            O_VIDEO_DATA_ENABLE <= 1'b0;
            O_HORIZONTAL_SYNC <= 1'b0;
            O_VERTICAL_SYNC <= 1'b0;
        end else begin
            de_cnt <= (de_diff && !de_take) ? de_cnt + 2'd1 : 2'd0;
            hs_cnt <= (hs_diff && !hs_take) ? hs_cnt + 2'd1 : 2'd0;
            if (de_take) begin
                O_VIDEO_DATA_ENABLE <= I_VIDEO_DATA_ENABLE;
            end
            if (hs_take) begin
                O_HORIZONTAL_SYNC <= I_HORIZONTAL_SYNC;
            end
            O_VERTICAL_SYNC <= I_VERTICAL_SYNC;
        end
    end
    // ==========================================
    // Checks
    a_pd_force_high: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        !I_POWER_DOWN_N |=> O_SERIAL_FORCE_HIGH && !O_PLL_ENABLE) else $error("power-down outputs wrong");
    a_run_pll_on: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        I_POWER_DOWN_N |=> O_PLL_ENABLE && !O_SERIAL_FORCE_HIGH) else $error("pll not on");
    a_pd_ctrl_clear: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        !I_POWER_DOWN_N |=> ctrl == 7'h00) else $error("ctrl not reset");
    a_selftest_follow: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (!override && I_POWER_DOWN_N) |=> O_SELF_TEST_ON == $past(I_SELF_TEST_ENABLE)) else $error("self-test");
    a_mode_legacy: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        eff_mode == 2'b10 |=> O_LEGACY_A && !O_LEGACY_B && !O_FILTER_ON) else $error("legacy A");
    a_mode_legacy_b: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        eff_mode == 2'b11 |=> O_LEGACY_B && !O_LEGACY_A) else $error("legacy B");
    a_mode_plain: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        eff_mode == 2'b00 |=> !O_FILTER_ON) else $error("filter on in mode 00");
    a_filter_drop: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (filter_sel && de_diff && de_cnt == 2'd0)
        |=> $stable(O_VIDEO_DATA_ENABLE)) else $error("short pulse passed");
    a_edge_follow: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        !override |=> O_LATCH_RISING == $past(I_LATCH_EDGE_SELECT)) else $error("edge select");
    a_swing_follow: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        !override |=> O_SWING_LARGE == $past(I_OUTPUT_SWING_SELECT)) else $error("swing select");
    a_preemph_float: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (I_PREEMPHASIS_CONTROL && !ctrl[5]) |=> !O_PREEMPH_ON) else $error("preemphasis on");
    a_hs_drop: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (filter_sel && hs_diff && hs_cnt == 2'd0) |=> $stable(O_HORIZONTAL_SYNC)) else $error("short hsync passed");
    a_de_pass: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (filter_sel && de_diff && de_cnt == 2'd0) ##1 (filter_sel && de_diff) ##1 (filter_sel && de_diff)
        |=> $changed(O_VIDEO_DATA_ENABLE)) else $error("long pulse dropped");
    a_hs_pass: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (filter_sel && hs_diff && hs_cnt == 2'd0) ##1 (filter_sel && hs_diff) ##1 (filter_sel && hs_diff)
        |=> $changed(O_HORIZONTAL_SYNC)) else $error("long hsync dropped");
    a_plain_de: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        !filter_sel |=> O_VIDEO_DATA_ENABLE == $past(I_VIDEO_DATA_ENABLE)) else $error("data enable delayed");
    a_plain_hs: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        !filter_sel |=> O_HORIZONTAL_SYNC == $past(I_HORIZONTAL_SYNC)) else $error("hsync delayed");
    a_vsync_pass: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        1'b1 |=> O_VERTICAL_SYNC == $past(I_VERTICAL_SYNC)) else $error("vsync delayed");
    a_mode_filtered: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        eff_mode == 2'b01 |=> O_FILTER_ON && !O_LEGACY_A && !O_LEGACY_B) else $error("filter mode");
    a_mode_b_plain: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        eff_mode == 2'b11 |=> !O_FILTER_ON) else $error("filter on in mode 11");
    a_mode_out: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        1'b1 |=> O_LINK_MODE == $past(eff_mode)) else $error("link mode out");
    a_override_mode: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        override |=> O_LINK_MODE == $past(ctrl[2:1])) else $error("register mode ignored");
    a_override_swing: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        override |=> O_SWING_LARGE == $past(ctrl[4])) else $error("register swing ignored");
    a_override_edge: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        override |=> O_LATCH_RISING == $past(ctrl[3])) else $error("register edge ignored");
    a_override_self: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (override && I_POWER_DOWN_N) |=> O_SELF_TEST_ON == $past(ctrl[0])) else $error("register self-test");
    a_pd_self_test: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        !I_POWER_DOWN_N |=> !O_SELF_TEST_ON) else $error("self-test in power-down");
    a_preemph_reg: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        ctrl[5] |=> O_PREEMPH_ON) else $error("register preemphasis ignored");
    // ==========================================
    // Bus checks; power-down drops a pending write on purpose
    a_pd_bus_block: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        !I_POWER_DOWN_N |=> !O_AWREADY && !O_WREADY && !O_BVALID) else $error("write open in power-down");
    a_aw_answer: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (aw_fire && w_fire && I_POWER_DOWN_N) |=> O_BVALID) else $error("no write response");
    a_b_hold: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (O_BVALID && !I_BREADY && I_POWER_DOWN_N) |=> O_BVALID && $stable(O_BRESP)) else $error("bvalid dropped");
    a_b_release: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (O_BVALID && I_BREADY) |=> !O_BVALID) else $error("bvalid stuck");
    a_ar_answer: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        ar_fire |=> O_RVALID && !O_ARREADY) else $error("no read response");
    a_r_hold: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (O_RVALID && !I_RREADY) |=> O_RVALID && $stable(O_RDATA) && $stable(O_RRESP)) else $error("rvalid dropped");
    a_r_release: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (O_RVALID && I_RREADY) |=> !O_RVALID) else $error("rvalid stuck");
    a_rd_ctrl: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (ar_fire && I_ARADDR == 8'h00) |=> O_RDATA == {25'h0000000, $past(ctrl)}) else $error("ctrl read data");
    a_rd_unmapped: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (ar_fire && I_ARADDR != 8'h00 && I_ARADDR != 8'h04)
        |=> O_RRESP == 2'b10 && O_RDATA == 32'h0000_0000) else $error("unmapped read");
    a_wr_ignored: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (wr_go && !wr_hit && I_POWER_DOWN_N) |=> $stable(ctrl)) else $error("stray write landed");
    a_strobe_off: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (wr_go && !wr_strb[0] && I_POWER_DOWN_N) |=> $stable(ctrl)) else $error("masked write landed");
    c_pd_entry: cover property (@(posedge I_MCLK) disable iff (!I_RST_N) $fell(I_POWER_DOWN_N));
    c_ctrl_write: cover property (@(posedge I_MCLK) disable iff (!I_RST_N) wr_go && wr_hit);
    c_filter_pass: cover property (@(posedge I_MCLK) disable iff (!I_RST_N) filter_sel && de_take && de_diff);
    c_read: cover property (@(posedge I_MCLK) disable iff (!I_RST_N) ar_fire);
endmodule : sercfg_top

// file: verif/serial_rx_model.sv
`timescale 1ns/1ns
// ====================
// Companion receiver
module serial_rx_model (
    // Clock
    input wire logic i_mclk,
    // Serial link state
    input wire logic i_force_high,
    input wire logic i_pll_enable,
    input wire logic [1:0] i_link_mode,
    // Lock indication
    output logic o_link_ok
);
    // Legacy formats are not decoded here, so they never lock
    wire fmt_ok = !i_link_mode[1];
    always_ff @(posedge i_mclk) begin
        o_link_ok <= fmt_ok && i_pll_enable && !i_force_high;
    end
endmodule : serial_rx_model

// file: verif/test_sercfg_top.sv
`timescale 1ns/1ns
module test_sercfg_top;
    // ====================
    // Signals
    logic I_MCLK, I_RST_N, I_SELF_TEST_ENABLE, I_POWER_DOWN_N, I_LATCH_EDGE_SELECT, I_OUTPUT_SWING_SELECT;
    logic I_PREEMPHASIS_CONTROL, I_VIDEO_DATA_ENABLE, I_HORIZONTAL_SYNC, I_VERTICAL_SYNC;
    logic I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, link_ok;
    logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_SELF_TEST_ON, O_FILTER_ON, O_LEGACY_A;
    logic O_LEGACY_B, O_LATCH_RISING, O_SWING_LARGE, O_PREEMPH_ON, O_PLL_ENABLE, O_SERIAL_FORCE_HIGH;
    logic O_VIDEO_DATA_ENABLE, O_HORIZONTAL_SYNC, O_VERTICAL_SYNC;
    logic [1:0] I_LINK_MODE, O_BRESP, O_RRESP, O_LINK_MODE, rresp, bresp;
    logic [7:0] I_AWADDR, I_ARADDR;
    logic [3:0] I_WSTRB;
    logic [31:0] I_WDATA, O_RDATA, seed, rdata;
    logic [5:0] pins;
    logic [6:0] ctrl;
    int bad_count, checks_done, cycles;

    sercfg_top dut_u (.I_MCLK, .I_RST_N, .I_SELF_TEST_ENABLE, .I_LINK_MODE, .I_POWER_DOWN_N,
        .I_LATCH_EDGE_SELECT, .I_OUTPUT_SWING_SELECT, .I_PREEMPHASIS_CONTROL, .I_VIDEO_DATA_ENABLE,
        .I_HORIZONTAL_SYNC, .I_VERTICAL_SYNC, .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB,
        .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA,
        .O_RRESP, .O_RVALID, .I_RREADY, .O_SELF_TEST_ON, .O_LINK_MODE, .O_FILTER_ON, .O_LEGACY_A,
        .O_LEGACY_B, .O_LATCH_RISING, .O_SWING_LARGE, .O_PREEMPH_ON, .O_PLL_ENABLE, .O_SERIAL_FORCE_HIGH,
        .O_VIDEO_DATA_ENABLE, .O_HORIZONTAL_SYNC, .O_VERTICAL_SYNC);
    serial_rx_model rx_u (.i_mclk(I_MCLK), .i_force_high(O_SERIAL_FORCE_HIGH), .i_pll_enable(O_PLL_ENABLE),
        .i_link_mode(O_LINK_MODE), .o_link_ok(link_ok));

    // ====================
    // Helpers
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // Pins {preemph pin, swing, edge, mode, self test}; override bit hands 4:0 to ctrl
    function logic [8:0] exp_cfg(input logic [6:0] c, input logic [5:0] p);
        logic [4:0] s;
        s = c[6] ? c[4:0] : p[4:0];
        return {!p[5] || c[5], s[4], s[3], s[2:1] == 2'b11, s[2:1] == 2'b10, s[2:1] == 2'b01, s[2:1], s[0]};
    endfunction : exp_cfg

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk

    task set_pins(input logic [5:0] p);
        pins = p;
        {I_PREEMPHASIS_CONTROL, I_OUTPUT_SWING_SELECT, I_LATCH_EDGE_SELECT, I_LINK_MODE, I_SELF_TEST_ENABLE} <= p;
    endtask : set_pins

    // Ready is registered, so its level at the falling edge is what the next rising edge samples
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        {I_AWADDR, I_WDATA, I_WSTRB} <= {a, d, 4'hf};
        {I_AWVALID, I_WVALID, I_BREADY} <= 3'b111;
        do begin
            @(negedge I_MCLK);
            aw_t = I_AWVALID && O_AWREADY;
            w_t = I_WVALID && O_WREADY;
            b_t = O_BVALID;
            bresp = O_BRESP;
            @(posedge I_MCLK);
            if (aw_t) I_AWVALID <= 1'b0;
            if (w_t) I_WVALID <= 1'b0;
        end while (!b_t);
        I_BREADY <= 1'b0;
        @(posedge I_MCLK);
    endtask : wr

    task rd(input logic [7:0] a);
        logic ar_t, r_t;
        {I_ARADDR, I_ARVALID, I_RREADY} <= {a, 2'b11};
        do begin
            @(negedge I_MCLK);
            ar_t = I_ARVALID && O_ARREADY;
            r_t = O_RVALID;
            {rresp, rdata} = {O_RRESP, O_RDATA};
            @(posedge I_MCLK);
            if (ar_t) I_ARVALID <= 1'b0;
        end while (!r_t);
        I_RREADY <= 1'b0;
        @(posedge I_MCLK);
    endtask : rd

    task cfg_chk(input logic [6:0] c);
        repeat (3) @(posedge I_MCLK);
        @(negedge I_MCLK);
        chk("config", exp_cfg(c, pins), {O_PREEMPH_ON, O_SWING_LARGE, O_LATCH_RISING, O_LEGACY_B, O_LEGACY_A,
            O_FILTER_ON, O_LINK_MODE, O_SELF_TEST_ON});
        @(posedge I_MCLK);
    endtask : cfg_chk

    task pulse(input logic [1:0] m, input int len, input logic e);
        logic sde, shs;
        set_pins({pins[5:3], m, pins[0]});
        repeat (130) @(posedge I_MCLK);
        {I_VIDEO_DATA_ENABLE, I_HORIZONTAL_SYNC, sde, shs} <= 4'b1100;
        repeat (len) @(posedge I_MCLK);
        {I_VIDEO_DATA_ENABLE, I_HORIZONTAL_SYNC} <= 2'b00;
        repeat (6) begin
            @(negedge I_MCLK);
            sde |= O_VIDEO_DATA_ENABLE;
            shs |= O_HORIZONTAL_SYNC;
        end
        @(posedge I_MCLK);
        chk("data enable pulse", e, sde);
        chk("hsync pulse", e, shs);
    endtask : pulse

    task wrap_up;
        $display("checks_done %0d bad_count %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up

    // ====================
    // Clock, watchdog, sequence
    initial begin
        I_MCLK = 1'b0;
        forever #20 I_MCLK = ~I_MCLK;
    end

    // Whole run needs about 600 cycles
    always @(posedge I_MCLK) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    initial begin
        {I_RST_N, I_POWER_DOWN_N, I_VIDEO_DATA_ENABLE, I_HORIZONTAL_SYNC, I_VERTICAL_SYNC} = 5'b01000;
        {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_AWADDR, I_ARADDR, I_WDATA, I_WSTRB} = '0;
        {I_PREEMPHASIS_CONTROL, I_OUTPUT_SWING_SELECT, I_LATCH_EDGE_SELECT, I_LINK_MODE, I_SELF_TEST_ENABLE} = 6'h20;
        pins = 6'h20;
        seed = 32'd37744;
        repeat (5) @(posedge I_MCLK);
        I_RST_N <= 1'b1;
        @(posedge I_MCLK);
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            ctrl = seed[12:6];
            set_pins({seed[5:3], i[1:0], seed[0]});
            wr(sercfg_pkg::CTRL_OFFSET, {25'h0, ctrl});
            chk("ctrl write resp", {30'h0, sercfg_pkg::RESP_OKAY}, {30'h0, bresp});
            cfg_chk(ctrl);
            rd(sercfg_pkg::CTRL_OFFSET);
            chk("ctrl readback", {25'h0, ctrl}, rdata);
        end
        rd(8'h10);
        chk("unmapped resp", {30'h0, sercfg_pkg::RESP_SLVERR}, {30'h0, rresp});
        chk("unmapped data", 32'h0, rdata);
        wr(8'h10, 32'h0);
        chk("unmapped write resp", {30'h0, sercfg_pkg::RESP_SLVERR}, {30'h0, bresp});
        wr(sercfg_pkg::CTRL_OFFSET, 32'h0);
        pulse(2'b01, 2, 1'b0);
        pulse(2'b01, 3, 1'b1);
        pulse(2'b00, 1, 1'b1);
        I_VERTICAL_SYNC <= 1'b1;
        @(posedge I_MCLK);
        @(negedge I_MCLK);
        chk("vsync", 1, O_VERTICAL_SYNC);
        chk("link power", 32'h2, {O_PLL_ENABLE, O_SERIAL_FORCE_HIGH});
        chk("link lock", 1, link_ok);
        @(posedge I_MCLK);
        wr(sercfg_pkg::CTRL_OFFSET, 32'h7f);
        I_POWER_DOWN_N <= 1'b0;
        repeat (3) @(posedge I_MCLK);
        @(negedge I_MCLK);
        chk("down power", 32'h1, {O_PLL_ENABLE, O_SERIAL_FORCE_HIGH});
        chk("down lock", 0, link_ok);
        @(posedge I_MCLK);
        I_POWER_DOWN_N <= 1'b1;
        cfg_chk(7'h00);
        rd(sercfg_pkg::CTRL_OFFSET);
        chk("ctrl after power-down", 32'h0, rdata);
        rd(sercfg_pkg::STATUS_OFFSET);
        chk("status", {1'b1, !pins[5], pins[4], pins[3], 1'b1}, rdata[4:0]);
        wrap_up();
    end
endmodule : test_sercfg_top
